// ==== testbench/testbench.sv ====
// self-checking bench for the watchdog timer monitor over its apb port
`timescale 1ns/1ps
module testbench;
    // system
    logic        clock;
    logic        reset;
    // apb master side
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // watchdog outputs
    logic        sysResetReq;
    logic        wdIntReq;
    logic        irq;
    // bench bookkeeping
    int          n_mismatch = 0;
    int          n_checks   = 0;
    int          cycles     = 0;
    logic [31:0] v;
    logic        e;
    int          n;
    int          h;
    bit          seen;

    // short tap base keeps the four intervals at 8, 64, 512 and 4096 clocks
    localparam int TB_TAP = 3;

    wdtm_top #(.TAP_BASE(TB_TAP)) u_dut (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sysResetReq(sysResetReq), .wdIntReq(wdIntReq), .irq(irq));

    // 250 MHz system clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // expected interval length for a select code
    function automatic int tapLen(input int sel);
        return 1 << (TB_TAP + 3 * sel);
    endfunction

    // verdict and end of run, the only exit point
    task automatic conclude();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; psel stays up when another setup follows at once
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input bit last, output logic [31:0] rd, output logic err);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) n_mismatch++;
        rd = prdata;
        err = pslverr;
        penable <= 1'b0;
        // an idle edge after the last transfer, so psel is never set twice at once
        if (last) begin
            psel <= 1'b0;
            @(posedge clock);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        x;
        xfer(1'b1, a, d, 1'b1, r, x);
    endtask

    task automatic rdReg(input logic [7:0] a, output logic [31:0] r);
        logic x;
        xfer(1'b0, a, 32'h0, 1'b1, r, x);
    endtask

    // key pair then the protected write, all back to back
    task automatic unlockWr(input logic [31:0] d);
        logic [31:0] r;
        logic        x;
        xfer(1'b1, wdtm_pkg::OFF_TAKEY, 32'h000000AA, 1'b0, r, x);
        xfer(1'b1, wdtm_pkg::OFF_TAKEY, 32'h00000055, 1'b0, r, x);
        xfer(1'b1, wdtm_pkg::OFF_WDCTRL, d, 1'b1, r, x);
    endtask

    // hang guard, sized well above the longest scenario
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_mismatch++;
            conclude();
        end
    end

    // main sequence
    initial begin
        reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0;
        void'($urandom(32'hB710));
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        // reset state and read-only fields
        rdReg(wdtm_pkg::OFF_CLKCTRL, v); chk(v & 32'hC0, 32'h0);
        rdReg(wdtm_pkg::OFF_WDCTRL, v); chk(v & 32'h0F, 32'h0);
        rdReg(wdtm_pkg::OFF_INTEN, v); chk(32'(v[19:8]), 32'hB6B);
        rdReg(wdtm_pkg::OFF_COUNT, v); chk(32'(v[22:21]), 32'h0);
        xfer(1'b0, 8'h1C, 32'h0, 1'b1, v, e); chk(32'(e), 32'h1);
        // protected write with no key is dropped, watchdog stays off
        wr(wdtm_pkg::OFF_WDCTRL, 32'h3);
        rdReg(wdtm_pkg::OFF_COUNT, v); chk(32'(v[22:21]), 32'h0);
        // every interval code, random filler in the unused upper bits
        for (int s = 0; s < 4; s++) begin
            wr(wdtm_pkg::OFF_CLKCTRL, {$urandom() & 32'hFFFFFF00} | 32'(s << 6));
            rdReg(wdtm_pkg::OFF_CLKCTRL, v); chk(32'(v[7:6]), 32'(s));
            unlockWr(32'h1);
            rdReg(wdtm_pkg::OFF_WDCTRL, v); chk(32'(v[0]), 32'h0);
            if (s > 0) begin
                repeat (tapLen(s) / 2) @(posedge clock);
                rdReg(wdtm_pkg::OFF_WDCTRL, v); chk(32'(v[3]), 32'h0);
            end
            repeat (tapLen(s) / 2 + 8) @(posedge clock);
            rdReg(wdtm_pkg::OFF_WDCTRL, v); chk(32'(v[3]), 32'h1);
        end
        // interrupt: mask, raise, read-clear; then the core request gating
        wr(wdtm_pkg::OFF_MASK, 32'h1);
        repeat (3) @(posedge clock); chk(32'(irq), 32'h1);
        rdReg(wdtm_pkg::OFF_STAT, v); chk(32'(v[0]), 32'h1);
        repeat (3) @(posedge clock); chk(32'(irq), 32'h0);
        wr(wdtm_pkg::OFF_INTEN, 32'hA0);
        repeat (3) @(posedge clock); chk(32'(wdIntReq), 32'h1);
        wr(wdtm_pkg::OFF_INTEN, 32'h20);
        repeat (3) @(posedge clock); chk(32'(wdIntReq), 32'h0);
        // flag clear needs the key first
        wr(wdtm_pkg::OFF_WDCTRL, 32'h0);
        rdReg(wdtm_pkg::OFF_WDCTRL, v); chk(32'(v[3]), 32'h1);
        unlockWr(32'h0);
        rdReg(wdtm_pkg::OFF_WDCTRL, v); chk(32'(v[3]), 32'h0);
        // reset enabled, shortest interval, no restart in the final grace time
        wr(wdtm_pkg::OFF_CLKCTRL, 32'h0);
        wr(wdtm_pkg::OFF_MASK, 32'h3);
        unlockWr(32'h3);
        // a restart inside the grace time holds the reset off until the end of the next grace
        repeat (300) @(posedge clock);
        unlockWr(32'h3);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (sysResetReq !== 1'b1 && n < 2000);
        chk(32'(n >= tapLen(0) + 510 && n <= tapLen(0) + 522), 32'h1);
        h = 0;
        while (sysResetReq === 1'b1 && h < 20) begin
            h++;
            @(posedge clock);
        end
        chk(32'(h), 32'(wdtm_pkg::RST_HOLD_CLKS));
        rdReg(wdtm_pkg::OFF_WDCTRL, v); chk(32'(v[3:2]), 32'h1);
        rdReg(wdtm_pkg::OFF_STAT, v); chk(32'(v[1]), 32'h1);
        rdReg(wdtm_pkg::OFF_COUNT, v); chk(32'(v[22:21] != 2'b00), 32'h1);
        // disable reset and clear the cause; counter must keep running
        unlockWr(32'h0);
        rdReg(wdtm_pkg::OFF_WDCTRL, v); chk(32'(v[2]), 32'h0);
        seen = 1'b0;
        repeat (700) begin
            @(posedge clock);
            if (sysResetReq === 1'b1) seen = 1'b1;
        end
        chk(32'(seen), 32'h0);
        rdReg(wdtm_pkg::OFF_WDCTRL, v); chk(32'(v[3:2]), 32'h2);
        // power reset in mid-run turns the watchdog off and clears flags
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rdReg(wdtm_pkg::OFF_COUNT, v); chk(32'(v[22:21]), 32'h0);
        rdReg(wdtm_pkg::OFF_WDCTRL, v); chk(32'(v[3:0]), 32'h0);
        conclude();
    end
endmodule

// ==== verilog/wdtm_pkg.sv ====
// watchdog timer monitor: shared offsets, bit positions, reset values and timing
package wdtm_pkg;

    // apb byte offsets
    localparam logic [7:0] OFF_WDCTRL  = 8'h00; // watchdog_control
    localparam logic [7:0] OFF_CLKCTRL = 8'h04; // clock_control
    localparam logic [7:0] OFF_INTEN   = 8'h08; // interrupt enables, vector readback
    localparam logic [7:0] OFF_TAKEY   = 8'h0C; // timed-access key
    localparam logic [7:0] OFF_STAT    = 8'h10; // sticky event status
    localparam logic [7:0] OFF_MASK    = 8'h14; // event mask
    localparam logic [7:0] OFF_COUNT   = 8'h18; // counter and state readback

    // watchdog_control fields
    localparam int WDC_TIMEOUT = 3; // timeout_flag
    localparam int WDC_CAUSE   = 2; // wd_reset_cause_flag
    localparam int WDC_RSTEN   = 1; // reset_function_enable
    localparam int WDC_RESTART = 0; // counter_restart_bit

    // clock_control fields
    localparam int CKC_SEL_HI = 7; // interval_select_high
    localparam int CKC_SEL_LO = 6; // interval_select_low

    // interrupt enable fields
    localparam int IEN_WD     = 5; // wd_int_enable
    localparam int IEN_GLOBAL = 7; // global_int_enable
    localparam int IEN_VEC_LO = 8; // vector readback, bits 15:8
    localparam int IEN_PRI_LO = 16; // priority readback, bits 19:16

    // status and mask fields
    localparam int STAT_TIMEOUT = 0;
    localparam int STAT_WDRESET = 1;

    // reset values
    localparam logic [7:0] CKC_RESET  = 8'h00; // shortest interval
    localparam logic [1:0] MASK_RESET = 2'h0;

    // timing
    localparam int CNT_W         = 21; // widest tap
    localparam int TAP_BASE_DEF  = 12; // code 00 tap
    localparam int TAP_STEP      = 3;  // taps 12, 15, 18, 21
    localparam int GRACE_CLKS    = 512;
    localparam int MC_CLKS       = 4;  // clocks per machine cycle
    localparam int RST_MC        = 2;
    localparam int RST_HOLD_CLKS = MC_CLKS * RST_MC;
    localparam int TA_WINDOW_MC  = 3;
    localparam int TA_WINDOW_CLKS = MC_CLKS * TA_WINDOW_MC;

    // timed-access keys
    localparam logic [7:0] TA_KEY1 = 8'hAA;
    localparam logic [7:0] TA_KEY2 = 8'h55;

    // interrupt position
    localparam logic [7:0] WD_INT_VECTOR = 8'h6B;
    localparam logic [3:0] WD_INT_PRIO   = 4'hB; // lowest of eleven

    // watchdog sequencer states
    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_COUNT = 2'b01,
        ST_GRACE = 2'b10,
        ST_RESET = 2'b11
    } wdtm_state_t;

endpackage

// ==== verilog/wdtm_sticky.sv ====
// sticky event flags where a set beats a clear in the same cycle
`timescale 1ns/1ps
module wdtm_sticky #(
    parameter int WIDTH = 2
) (
    // system
    input  wire logic             clock,
    input  wire logic             reset,
    // events and clears
    input  wire logic [WIDTH-1:0] setBits,
    input  wire logic [WIDTH-1:0] clrBits,
    // held flags
    output logic      [WIDTH-1:0] flags
);

    // set wins so an event landing on the clearing read is kept
    always_ff @(posedge clock) begin
        if (reset) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clrBits) | setBits;
        end
    end

endmodule

// ==== verilog/wdtm_timed_access.sv ====
// timed-access unlock: two key writes open a short protected-write window
`timescale 1ns/1ps
module wdtm_timed_access (
    // system
    input  wire logic       clock,
    input  wire logic       reset,
    // key register writes
    input  wire logic       keyWrite,
    input  wire logic [7:0] keyData,
    // a protected write used the window
    input  wire logic       protUsed,
    // window state
    output logic            windowOpen
);

    logic       armed_r;     // first key seen
    logic [3:0] windowCnt_r; // clocks left in window

    // any key write other than the first key disarms
    always_ff @(posedge clock) begin
        if (reset) begin
            armed_r <= 1'b0;
        end else if (keyWrite) begin
            armed_r <= (keyData == wdtm_pkg::TA_KEY1);
        end
    end

    // window lasts a few machine cycles or one protected write
    always_ff @(posedge clock) begin
        if (reset) begin
            windowCnt_r <= 4'h0;
        end else if (keyWrite && armed_r && keyData == wdtm_pkg::TA_KEY2) begin
            windowCnt_r <= 4'(wdtm_pkg::TA_WINDOW_CLKS);
        end else if (protUsed) begin
            windowCnt_r <= 4'h0;
        end else if (windowCnt_r != 4'h0) begin
            windowCnt_r <= windowCnt_r - 4'h1;
        end
    end

    assign windowOpen = (windowCnt_r != 4'h0);

endmodule

// ==== verilog/wdtm_top.sv ====
// watchdog timer monitor: counter, reset sequencer, apb registers, interrupt
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - free-running counter on the system clock
// - two select bits pick tap 12/15/18/21
// - reaching interval sets the time-out flag
// - 512 more clocks, then reset if enabled
// - reset held two machine cycles, cause flagged
// - restart bit clears counter, then self-clears
// - cause flag cleared by software or power reset
// - time-out flag cleared by software or reset
// - interrupt needs flag, own and global enable
// - reset enable bit; counter runs when off
// - watchdog reset restarts; power reset disables
// - flag still set with interrupt, reset off
// - interval select defaults to shortest
// - protected bits need timed access first
// - lowest priority, vector 6Bh, software clear
module wdtm_top #(
    parameter int TAP_BASE = wdtm_pkg::TAP_BASE_DEF // lower for fast simulation
) (
    // system
    input  wire logic        clock,
    input  wire logic        reset,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // watchdog outputs
    output logic             sysResetReq,
    output logic             wdIntReq,
    output logic             irq
);

    // sequencer and counters
    wdtm_pkg::wdtm_state_t state_r;   // sequencer state
    wdtm_pkg::wdtm_state_t state_nxt; // next state
    logic [wdtm_pkg::CNT_W-1:0] cnt_r; // free-running divider
    logic [8:0]  graceCnt_r;           // clocks since time-out
    logic [2:0]  holdCnt_r;            // clocks of reset hold

    // software-visible control
    logic        timeoutFlag_r;  // time-out flag
    logic        causeFlag_r;    // watchdog caused a reset
    logic        rstEn_r;        // reset function enable
    logic        restartBit_r;   // restart request, self-clearing
    logic [7:0]  clockCtrl_r;    // clock_control image
    logic        wdIntEn_r;      // watchdog interrupt enable
    logic        globalIntEn_r;  // global interrupt enable
    logic [1:0]  mask_r;         // event mask

    // derived
    logic [4:0]  tapLog2;        // selected tap position
    logic [wdtm_pkg::CNT_W-1:0] intervalMask;
    logic        running;        // counter advancing
    logic        timeoutHit;     // selected interval completed
    logic        graceDone;      // grace window over
    logic        holdDone;       // reset hold over
    logic        enterReset;     // watchdog reset starts
    logic [1:0]  status;         // sticky events
    logic        taOpen;         // timed-access window open

    // apb decode
    logic        setup;
    logic        access;
    logic        wrEn;
    logic        rdEn;
    logic        wrWdc;
    logic        protOk;
    logic        keyWrite;
    logic [31:0] rdValue;
    logic        rdHit;

    // transfer phases; writes act only at the completing access edge
    assign setup    = psel && !penable;
    assign access   = psel && penable && pready;
    assign wrEn     = access && pwrite;
    assign rdEn     = access && !pwrite;
    assign wrWdc    = wrEn && (paddr == wdtm_pkg::OFF_WDCTRL);
    assign keyWrite = wrEn && (paddr == wdtm_pkg::OFF_TAKEY);
    assign protOk   = wrWdc && taOpen;

    // interval tap from the select bits, taps three apart
    assign tapLog2 = 5'(TAP_BASE)
                   + 5'(clockCtrl_r[wdtm_pkg::CKC_SEL_HI:wdtm_pkg::CKC_SEL_LO])
                   * 5'(wdtm_pkg::TAP_STEP);
    assign intervalMask = ~({wdtm_pkg::CNT_W{1'b1}} << tapLog2);

    // time-out whenever the low tap bits all reach one, every wrap
    assign running    = (state_r == wdtm_pkg::ST_COUNT) || (state_r == wdtm_pkg::ST_GRACE);
    assign timeoutHit = running && !restartBit_r
                      && ((cnt_r & intervalMask) == intervalMask);
    assign graceDone  = (graceCnt_r == 9'(wdtm_pkg::GRACE_CLKS - 1));
    assign holdDone   = (holdCnt_r == 3'(wdtm_pkg::RST_HOLD_CLKS - 1));
    assign enterReset = (state_r == wdtm_pkg::ST_GRACE) && (state_nxt == wdtm_pkg::ST_RESET);

    // sequencer: off until first restart, grace after a time-out in the count state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            wdtm_pkg::ST_OFF: begin
                if (restartBit_r) begin
                    state_nxt = wdtm_pkg::ST_COUNT;
                end
            end
            wdtm_pkg::ST_COUNT: begin
                if (!restartBit_r && timeoutHit) begin
                    state_nxt = wdtm_pkg::ST_GRACE;
                end
            end
            wdtm_pkg::ST_GRACE: begin
                if (restartBit_r) begin
                    state_nxt = wdtm_pkg::ST_COUNT;
                end else if (graceDone) begin
                    // disabled reset only ends the wait, counter runs on
                    state_nxt = rstEn_r ? wdtm_pkg::ST_RESET
                                        : wdtm_pkg::ST_COUNT;
                end
            end
            wdtm_pkg::ST_RESET: begin
                if (holdDone) begin
                    state_nxt = wdtm_pkg::ST_COUNT;
                end
            end
        endcase
    end

    // state register; power reset leaves the watchdog disabled
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= wdtm_pkg::ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // divider: cleared by restart or watchdog reset, else counts and wraps in count and grace, holds when off
    always_ff @(posedge clock) begin
        if (reset) begin
            cnt_r <= '0;
        end else if (restartBit_r || state_r == wdtm_pkg::ST_RESET) begin
            cnt_r <= '0;
        end else if (running) begin
            cnt_r <= cnt_r + {{(wdtm_pkg::CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // grace window counter runs only while waiting for a restart
    always_ff @(posedge clock) begin
        if (reset || state_r != wdtm_pkg::ST_GRACE) begin
            graceCnt_r <= 9'h000;
        end else begin
            graceCnt_r <= graceCnt_r + 9'h001;
        end
    end

    // reset hold counter, two machine cycles
    always_ff @(posedge clock) begin
        if (reset || state_r != wdtm_pkg::ST_RESET) begin
            holdCnt_r <= 3'h0;
        end else begin
            holdCnt_r <= holdCnt_r + 3'h1;
        end
    end

    // system reset request follows the reset state, from a flop
    always_ff @(posedge clock) begin
        if (reset) begin
            sysResetReq <= 1'b0;
        end else begin
            sysResetReq <= (state_nxt == wdtm_pkg::ST_RESET);
        end
    end

    // reset enable, written only inside the timed-access window
    always_ff @(posedge clock) begin
        if (reset) begin
            rstEn_r <= 1'b0;
        end else if (protOk) begin
            rstEn_r <= pwdata[wdtm_pkg::WDC_RSTEN];
        end
    end

    // restart bit lives one cycle, then hardware clears it
    always_ff @(posedge clock) begin
        if (reset) begin
            restartBit_r <= 1'b0;
        end else begin
            restartBit_r <= protOk && pwdata[wdtm_pkg::WDC_RESTART];
        end
    end

    // time-out flag: a hit beats a software write, a watchdog reset beats a hit
    always_ff @(posedge clock) begin
        if (reset) begin
            timeoutFlag_r <= 1'b0;
        end else if (enterReset) begin
            timeoutFlag_r <= 1'b0;
        end else if (timeoutHit) begin
            timeoutFlag_r <= 1'b1;
        end else if (protOk) begin
            timeoutFlag_r <= pwdata[wdtm_pkg::WDC_TIMEOUT];
        end
    end

    // cause flag: only a watchdog reset sets it, only reset enable allows that
    always_ff @(posedge clock) begin
        if (reset) begin
            causeFlag_r <= 1'b0;
        end else if (enterReset) begin
            causeFlag_r <= 1'b1;
        end else if (wrWdc && !pwdata[wdtm_pkg::WDC_CAUSE]) begin
            causeFlag_r <= 1'b0;
        end
    end

    // clock_control, unprotected; bits 5:0 kept for software
    always_ff @(posedge clock) begin
        if (reset) begin
            clockCtrl_r <= wdtm_pkg::CKC_RESET;
        end else if (wrEn && paddr == wdtm_pkg::OFF_CLKCTRL) begin
            clockCtrl_r <= pwdata[7:0];
        end
    end

    // interrupt enables and event mask
    always_ff @(posedge clock) begin
        if (reset) begin
            wdIntEn_r     <= 1'b0;
            globalIntEn_r <= 1'b0;
            mask_r        <= wdtm_pkg::MASK_RESET;
        end else if (wrEn && paddr == wdtm_pkg::OFF_INTEN) begin
            wdIntEn_r     <= pwdata[wdtm_pkg::IEN_WD];
            globalIntEn_r <= pwdata[wdtm_pkg::IEN_GLOBAL];
        end else if (wrEn && paddr == wdtm_pkg::OFF_MASK) begin
            mask_r        <= pwdata[1:0];
        end
    end

    // watchdog interrupt request to the core's controller
    always_ff @(posedge clock) begin
        if (reset) begin
            wdIntReq <= 1'b0;
        end else begin
            wdIntReq <= timeoutFlag_r && wdIntEn_r && globalIntEn_r;
        end
    end

    // timed-access unlock
    wdtm_timed_access u_unlock (
        .clock      (clock),
        .reset      (reset),
        .keyWrite   (keyWrite),
        .keyData    (pwdata[7:0]),
        .protUsed   (protOk),
        .windowOpen (taOpen)
    );

    // sticky events; a read clears only the bits it reported
    wdtm_sticky #(
        .WIDTH (2)
    ) u_status (
        .clock   (clock),
        .reset   (reset),
        .setBits ({enterReset, timeoutHit}),
        .clrBits ((rdEn && paddr == wdtm_pkg::OFF_STAT) ? prdata[1:0] : 2'h0),
        .flags   (status)
    );

    // level interrupt while any unmasked event is held
    always_ff @(posedge clock) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask_r);
        end
    end

    // read mux; unmapped offsets answer with an error
    always_comb begin
        rdValue = 32'h0000_0000;
        rdHit   = 1'b1;
        case (paddr)
            wdtm_pkg::OFF_WDCTRL: begin
                rdValue[wdtm_pkg::WDC_TIMEOUT] = timeoutFlag_r;
                rdValue[wdtm_pkg::WDC_CAUSE]   = causeFlag_r;
                rdValue[wdtm_pkg::WDC_RSTEN]   = rstEn_r;
                rdValue[wdtm_pkg::WDC_RESTART] = restartBit_r;
            end
            wdtm_pkg::OFF_CLKCTRL: begin
                rdValue[7:0] = clockCtrl_r;
            end
            wdtm_pkg::OFF_INTEN: begin
                rdValue[wdtm_pkg::IEN_WD]     = wdIntEn_r;
                rdValue[wdtm_pkg::IEN_GLOBAL] = globalIntEn_r;
                rdValue[wdtm_pkg::IEN_VEC_LO +: 8] = wdtm_pkg::WD_INT_VECTOR;
                rdValue[wdtm_pkg::IEN_PRI_LO +: 4] = wdtm_pkg::WD_INT_PRIO;
            end
            wdtm_pkg::OFF_TAKEY: begin
                rdValue[0] = taOpen;
            end
            wdtm_pkg::OFF_STAT: begin
                rdValue[1:0] = status;
            end
            wdtm_pkg::OFF_MASK: begin
                rdValue[1:0] = mask_r;
            end
            wdtm_pkg::OFF_COUNT: begin
                rdValue = {9'h000, state_r, cnt_r};
            end
            default: begin
                rdHit = 1'b0;
            end
        endcase
    end

    // answer registered in setup, so access completes with no wait state
    always_ff @(posedge clock) begin
        if (reset) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !rdHit;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rdValue;
            end
        end
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence graceExpire;
        (state_r == wdtm_pkg::ST_GRACE) && graceDone && rstEn_r && !restartBit_r;
    endsequence
    sequence resetHold;
        sysResetReq [*8] ##1 !sysResetReq;
    endsequence
    timeout_flag_a: assert property (timeoutHit && !enterReset |=> timeoutFlag_r)
        else $error("time-out did not set the flag");
    restart_clear_a: assert property (restartBit_r |=> !restartBit_r && cnt_r == '0)
        else $error("restart did not clear counter or bit");
    grace_reset_a: assert property (graceExpire |=> sysResetReq && causeFlag_r
                                    && !timeoutFlag_r)
        else $error("grace expiry did not raise reset");
    reset_hold_a: assert property ($rose(sysResetReq) |-> resetHold)
        else $error("watchdog reset not held two machine cycles");
    cause_only_a: assert property ($rose(causeFlag_r) |-> $past(rstEn_r))
        else $error("cause flag set with reset disabled");
    int_gate_a: assert property (wdIntReq |-> $past(timeoutFlag_r)
                                 && $past(globalIntEn_r))
        else $error("interrupt without flag and global enable");
    prot_block_a: assert property (wrWdc && !taOpen |=> $stable(rstEn_r))
        else $error("protected bit changed without unlock");
    grace_limit_a: assert property (graceExpire |-> ##1 state_r == wdtm_pkg::ST_RESET)
        else $error("enabled grace expiry missed reset state");
    power_off_a: assert property ($past(reset) |-> state_r == wdtm_pkg::ST_OFF)
        else $error("watchdog running after power reset");
endmodule
